/* design/pci_two_tier_arbiter.sv */
`timescale 1ns/1ps
// Functional notes
// - grant the bus among the bridge and up to six external masters.
// - each requester sits in a high or low tier set by the tier register.
// - after reset the bridge requester is in the high tier.
// - after reset all six external requesters are in the low tier.
// - bit 7 of the tier register selects whether an idle grant is parked on the bridge (clear) or left off (set).
// - six mask bits; a masked device's request is ignored.
// - with bit 7 of mask register set, record timeouts after 16 idle clocks.
// - with bit 6 of mask register set, auto-mask a device that times out.
// - clearing the auto-mask bit removes every automatic mask.
// - one timeout flag per external device in the flags register.
// - registers sit at config byte offsets dc, dd and de.
module pci_two_tier_arbiter
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [5:0] req_n,
	output logic [5:0] gnt_n,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic bridge_req,
	output logic bridge_gnt,
	input wire logic [7:0] cfg_addr,
	input wire logic cfg_wr_en,
	input wire logic [7:0] cfg_wr_data,
	input wire logic cfg_rd_en,
	output logic [7:0] cfg_rd_data
);
	typedef struct packed {
		logic [5:0] req_meta;
		logic [5:0] req_sync;
		logic frame_meta;
		logic frame_sync;
		logic irdy_meta;
		logic irdy_sync;
		arb_pkg::arb_state_e state;
		logic [6:0] gnt;
		logic [2:0] owner;
		logic [4:0] cnt;
		logic [2:0] last_hi;
		logic [2:0] last_lo;
		logic [7:0] tier;
		logic [7:0] mask;
		logic [5:0] auto_msk;
		logic [5:0] flags;
		logic [7:0] rd_data;
	} arb_state_s;

	arb_state_s s;
	arb_state_s next_s;
	logic [6:0] eff_req;
	logic [6:0] hi_req;
	logic [6:0] lo_req;
	logic bus_idle;
	logic timeout;
	logic [7:0] rd_mux;

	arb_if hi_if ();
	arb_if lo_if ();

	// ******************************
	// request qualification
	// ******************************
	assign eff_req = {bridge_req, s.req_sync & ~s.mask[5:0] & ~s.auto_msk};
	assign hi_req = eff_req & s.tier[6:0];
	assign lo_req = eff_req & ~s.tier[6:0];
	assign bus_idle = !s.frame_sync && !s.irdy_sync;
	assign timeout = s.state == arb_pkg::st_wait && !s.frame_sync && bus_idle
		&& eff_req[s.owner] && s.cnt == arb_pkg::TIMEOUT_CLKS - 5'h01;

	assign hi_if.req = hi_req;
	assign hi_if.last = s.last_hi;
	assign lo_if.req = lo_req;
	assign lo_if.last = s.last_lo;

	tier_picker u_hi (.port(hi_if.picker));
	tier_picker u_lo (.port(lo_if.picker));

	// ******************************
	// config read mux
	// ******************************
	always_comb
	begin
		case (cfg_addr)
			arb_pkg::OFS_TIER: rd_mux = s.tier;
			arb_pkg::OFS_MASK: rd_mux = {s.mask[7:6], s.mask[5:0] | s.auto_msk};
			arb_pkg::OFS_FLAGS: rd_mux = {2'h0, s.flags};
			default: rd_mux = 8'h00;
		endcase
	end

	// ******************************
	// next state
	// ******************************
	always_comb
	begin
		logic [5:0] set_f;
		logic [5:0] clr_f;
		set_f = 6'h00;
		clr_f = 6'h00;
		next_s = s;
		// pins cross in from the bus: two stages before use
		next_s.req_meta = ~req_n;
		next_s.req_sync = s.req_meta;
		next_s.frame_meta = !frame_n;
		next_s.frame_sync = s.frame_meta;
		next_s.irdy_meta = !irdy_n;
		next_s.irdy_sync = s.irdy_meta;
		if (cfg_rd_en)
			next_s.rd_data = rd_mux;
		if (cfg_wr_en && cfg_addr == arb_pkg::OFS_TIER)
			next_s.tier = cfg_wr_data;
		if (cfg_wr_en && cfg_addr == arb_pkg::OFS_MASK)
			next_s.mask = cfg_wr_data;
		// reading the flags clears them
		if (cfg_rd_en && cfg_addr == arb_pkg::OFS_FLAGS)
			clr_f = s.flags;
		case (s.state)
			arb_pkg::st_idle:
			begin
				next_s.cnt = 5'h00;
				if (s.frame_sync)
				begin
					// parked agent started a cycle on its own
					next_s.state = arb_pkg::st_busy;
					next_s.gnt = 7'h00;
				end
				else if (hi_if.hit)
				begin
					next_s.state = arb_pkg::st_wait;
					next_s.gnt = 7'h01 << hi_if.pick;
					next_s.owner = hi_if.pick;
					next_s.last_hi = hi_if.pick;
				end
				else if (lo_if.hit)
				begin
					next_s.state = arb_pkg::st_wait;
					next_s.gnt = 7'h01 << lo_if.pick;
					next_s.owner = lo_if.pick;
					next_s.last_lo = lo_if.pick;
				end
				else if (!s.tier[arb_pkg::PARK_BIT])
				begin
					next_s.gnt = 7'h01 << arb_pkg::BRIDGE_IDX;
					next_s.owner = arb_pkg::BRIDGE_IDX;
				end
			end
			arb_pkg::st_wait:
			begin
				if (s.frame_sync)
				begin
					next_s.state = arb_pkg::st_busy;
					next_s.gnt = 7'h00;
				end
				else if (!eff_req[s.owner])
				begin
					// request withdrawn or masked: give the bus back
					next_s.state = arb_pkg::st_idle;
					next_s.gnt = 7'h00;
				end
				else if (timeout)
				begin
					next_s.state = arb_pkg::st_idle;
					next_s.gnt = 7'h00;
					if (s.owner != arb_pkg::BRIDGE_IDX)
					begin
						if (s.mask[arb_pkg::TO_EN_BIT])
							set_f[s.owner] = 1'b1;
						if (s.mask[arb_pkg::AUTO_BIT])
							next_s.auto_msk[s.owner] = 1'b1;
					end
				end
				else if (bus_idle)
					next_s.cnt = s.cnt + 5'h01;
			end
			arb_pkg::st_busy:
			begin
				if (bus_idle)
					next_s.state = arb_pkg::st_idle;
			end
			default:
			begin
				next_s.state = arb_pkg::st_idle;
				next_s.gnt = 7'h00;
			end
		endcase
		// a timeout landing on the clearing read still sticks
		next_s.flags = (s.flags & ~clr_f) | set_f;
		if (!next_s.mask[arb_pkg::AUTO_BIT])
			next_s.auto_msk = 6'h00;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			s <= '0;
			s.state <= arb_pkg::st_idle;
			s.tier <= arb_pkg::TIER_RESET;
			s.mask <= arb_pkg::MASK_RESET;
			s.flags <= arb_pkg::FLAGS_RESET;
		end
		else
			s <= next_s;
	end

	assign gnt_n = ~s.gnt[5:0];
	assign bridge_gnt = s.gnt[6];
	assign cfg_rd_data = s.rd_data;

	// ******************************
	// checks
	// ******************************
	localparam int TO_MAX = 40;
	logic tier_written;

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			tier_written <= 1'b0;
		else if (cfg_wr_en && cfg_addr == arb_pkg::OFS_TIER)
			tier_written <= 1'b1;
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	sequence new_grant;
		s.state == arb_pkg::st_idle ##1 s.state == arb_pkg::st_wait;
	endsequence

	sequence tmo_hit;
		timeout && s.owner != arb_pkg::BRIDGE_IDX;
	endsequence

	a_single_grant: assert property ($onehot0(s.gnt))
		else $error("more than one grant");
	a_tier_default: assert property (!tier_written |-> s.tier == arb_pkg::TIER_RESET)
		else $error("tier register lost reset value");
	a_mask_blocks: assert property (new_grant |-> (s.gnt[5:0] & $past(s.mask[5:0])) == 6'h00)
		else $error("masked device granted");
	a_high_first: assert property (new_grant ##0 (s.gnt & ~$past(s.tier[6:0])) != 7'h00
		|-> $past(hi_req) == 7'h00)
		else $error("low tier served over high tier");
	a_wait_bound: assert property (s.state == arb_pkg::st_wait
		|-> ##[1:TO_MAX] s.state != arb_pkg::st_wait)
		else $error("grant waited too long");
	a_flag_set: assert property ((tmo_hit and s.mask[arb_pkg::TO_EN_BIT])
		|=> s.flags[$past(s.owner)] && s.gnt == 7'h00)
		else $error("timeout not recorded");
	a_auto_mask: assert property ((tmo_hit and s.mask[arb_pkg::AUTO_BIT])
		|=> s.auto_msk[$past(s.owner)])
		else $error("timeout did not auto-mask");
	a_auto_clear: assert property (!s.mask[arb_pkg::AUTO_BIT] |-> s.auto_msk == 6'h00)
		else $error("automatic mask survived");
	a_park_bridge: assert property (s.state == arb_pkg::st_idle && eff_req == 7'h00
		&& !s.frame_sync && !s.tier[arb_pkg::PARK_BIT] |=> s.gnt[6])
		else $error("grant not parked on bridge");
	a_read_mask: assert property (cfg_rd_en && cfg_addr == arb_pkg::OFS_MASK
		|=> cfg_rd_data[7:6] == $past(s.mask[7:6]))
		else $error("mask readback wrong");
endmodule

/* design/tier_picker.sv */
`timescale 1ns/1ps
// rotating search, starting just past the last winner of this tier
module tier_picker
(
	arb_if.picker port
);
	always_comb
	begin
		int c;
		c = 0;
		port.pick = port.last;
		port.hit = 1'b0;
		for (int i = 1; i <= arb_pkg::N_AGENT; i++)
		begin
			c = (int'(port.last) + i) % arb_pkg::N_AGENT;
			if (!port.hit && port.req[c])
			begin
				port.hit = 1'b1;
				port.pick = 3'(c);
			end
		end
	end
endmodule

/* include/arb_if.sv */
`timescale 1ns/1ps
interface arb_if;
	logic [6:0] req;
	logic [2:0] last;
	logic [2:0] pick;
	logic hit;
	modport picker (input req, input last, output pick, output hit);
	modport user (output req, output last, input pick, input hit);
endinterface

/* include/arb_pkg.sv */
package arb_pkg;
	localparam int N_EXT = 6;
	localparam int N_AGENT = 7;
	localparam logic [2:0] BRIDGE_IDX = 3'h6;
	localparam logic [7:0] OFS_TIER = 8'hdc;
	localparam logic [7:0] OFS_MASK = 8'hdd;
	localparam logic [7:0] OFS_FLAGS = 8'hde;
	localparam logic [7:0] TIER_RESET = 8'h40;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [5:0] FLAGS_RESET = 6'h00;
	localparam int PARK_BIT = 7;
	localparam int BRIDGE_TIER_BIT = 6;
	localparam int AUTO_BIT = 6;
	localparam int TO_EN_BIT = 7;
	localparam logic [4:0] TIMEOUT_CLKS = 5'h10;
	typedef enum logic [1:0] {st_idle, st_wait, st_busy} arb_state_e;
endpackage

/* verification/pci_master_model.sv */
`timescale 1ns/1ps
// ************
// six external masters
// ************
module pci_master_model
(
	input wire logic clk_sys,
	input wire logic [5:0] want,
	input wire logic respond,
	input wire logic [5:0] gnt_n,
	output logic [5:0] req_n,
	output logic frame_n,
	output logic irdy_n
);
	logic [1:0] cnt = 2'h0;
	assign req_n = ~want;
	// released lines float up to the pull-up level
	assign frame_n = (cnt == 2'h0);
	assign irdy_n = (cnt == 2'h0);
	// a silent master never starts a frame, to provoke the timeout
	always @(posedge clk_sys)
		if (cnt != 2'h0)
			cnt <= cnt - 2'h1;
		else if (respond && |(~gnt_n & want))
			cnt <= 2'h3;
endmodule

/* verification/pci_two_tier_arbiter_tb.sv */
`timescale 1ns/1ps
module pci_two_tier_arbiter_tb;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [5:0] want = 6'h00;
	logic respond = 1'b1;
	logic bridge_req = 1'b0;
	logic [5:0] req_n, gnt_n;
	logic frame_n, irdy_n, bridge_gnt;
	logic [7:0] cfg_addr = 8'h00, cfg_wr_data = 8'h00, cfg_rd_data;
	logic cfg_wr_en = 1'b0, cfg_rd_en = 1'b0;
	int bad_count = 0, check_count = 0;
	// ************
	// design and far side
	// ************
	pci_two_tier_arbiter u_pci_two_tier_arbiter (.clk_sys(clk_sys), .resetn(resetn),
		.req_n(req_n), .gnt_n(gnt_n), .frame_n(frame_n), .irdy_n(irdy_n),
		.bridge_req(bridge_req), .bridge_gnt(bridge_gnt), .cfg_addr(cfg_addr),
		.cfg_wr_en(cfg_wr_en), .cfg_wr_data(cfg_wr_data), .cfg_rd_en(cfg_rd_en),
		.cfg_rd_data(cfg_rd_data));
	pci_master_model u_pci_master_model (.clk_sys(clk_sys), .want(want), .respond(respond),
		.gnt_n(gnt_n), .req_n(req_n), .frame_n(frame_n), .irdy_n(irdy_n));
	initial
	begin
		forever #20 clk_sys = ~clk_sys;
	end
	// ************
	// helpers
	// ************
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		cfg_addr <= a;
		cfg_wr_data <= d;
		cfg_wr_en <= 1'b1;
		@(posedge clk_sys);
		cfg_wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk_sys);
		cfg_addr <= a;
		cfg_rd_en <= 1'b1;
		@(posedge clk_sys);
		cfg_rd_en <= 1'b0;
		#1;
		chk(what, cfg_rd_data, exp);
	endtask
	// bounded wait for any external grant, looked at off the launching edge
	task automatic wait_gnt();
		for (int i = 0; i < 20 && gnt_n === 6'h3f; i++)
		begin
			@(posedge clk_sys);
			#1;
		end
	endtask
	// bounded wait for the external grants to drop
	task automatic wait_free();
		for (int i = 0; i < 20 && gnt_n !== 6'h3f; i++)
		begin
			@(posedge clk_sys);
			#1;
		end
	endtask
	// ************
	// scenarios
	// ************
	task automatic t_reset();
		rd(8'hdc, 8'h40, "tier");
		rd(8'hdd, 8'h00, "mask");
		rd(8'hde, 8'h00, "flags");
		wr(8'hde, 8'h3f);
		rd(8'hde, 8'h00, "flags ro");
		rd(8'h9c, 8'h00, "unmapped");
		chk("park", {7'h00, bridge_gnt}, 8'h01);
	endtask
	task automatic t_grant();
		@(posedge clk_sys);
		want <= 6'h04;
		wait_gnt();
		chk("gnt", {2'h0, gnt_n}, 8'h3b);
		chk("bridge off", {7'h00, bridge_gnt}, 8'h00);
		@(posedge clk_sys);
		want <= 6'h00;
		repeat (12) @(posedge clk_sys);
		#1;
		chk("repark", {7'h00, bridge_gnt}, 8'h01);
	endtask
	task automatic t_tier();
		wr(8'hdc, 8'h02);
		@(posedge clk_sys);
		want <= 6'h03;
		wait_gnt();
		chk("high first", {2'h0, gnt_n}, 8'h3d);
		@(posedge clk_sys);
		want <= 6'h00;
		wr(8'hdc, 8'h40);
		repeat (12) @(posedge clk_sys);
	endtask
	task automatic t_mask();
		wr(8'hdd, 8'h04);
		@(posedge clk_sys);
		want <= 6'h04;
		repeat (15) @(posedge clk_sys);
		#1;
		chk("masked", {2'h0, gnt_n}, 8'h3f);
		@(posedge clk_sys);
		want <= 6'h00;
		wr(8'hdd, 8'h00);
	endtask
	task automatic t_timeout();
		wr(8'hdd, 8'hc0);
		@(posedge clk_sys);
		respond <= 1'b0;
		want <= 6'h08;
		wait_gnt();
		chk("to gnt", {2'h0, gnt_n}, 8'h37);
		repeat (25) @(posedge clk_sys);
		#1;
		chk("auto off", {2'h0, gnt_n}, 8'h3f);
		rd(8'hde, 8'h08, "to flag");
		rd(8'hde, 8'h00, "flag clr");
		rd(8'hdd, 8'hc8, "auto mask");
		wr(8'hdd, 8'h80);
		rd(8'hdd, 8'h80, "unmask");
		@(posedge clk_sys);
		want <= 6'h00;
		respond <= 1'b1;
	endtask
	// two low-tier masters take turns; park bit set keeps the bus unparked
	task automatic t_rotate();
		wr(8'hdc, 8'hc0);
		@(posedge clk_sys);
		want <= 6'h03;
		wait_gnt();
		chk("rr first", {2'h0, gnt_n}, 8'h3e);
		wait_free();
		wait_gnt();
		chk("rr second", {2'h0, gnt_n}, 8'h3d);
		@(posedge clk_sys);
		want <= 6'h00;
		repeat (12) @(posedge clk_sys);
		#1;
		chk("no park", {7'h00, bridge_gnt}, 8'h00);
		chk("no park ext", {2'h0, gnt_n}, 8'h3f);
		wr(8'hdc, 8'h40);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("park back", {7'h00, bridge_gnt}, 8'h01);
	endtask
	// bridge in the high tier beats a low-tier master until it lets go
	task automatic t_bridge();
		@(posedge clk_sys);
		bridge_req <= 1'b1;
		want <= 6'h01;
		repeat (5) @(posedge clk_sys);
		#1;
		chk("bridge high", {2'h0, gnt_n}, 8'h3f);
		chk("bridge gnt", {7'h00, bridge_gnt}, 8'h01);
		@(posedge clk_sys);
		bridge_req <= 1'b0;
		wait_gnt();
		chk("dev after bridge", {2'h0, gnt_n}, 8'h3e);
		@(posedge clk_sys);
		want <= 6'h00;
		repeat (12) @(posedge clk_sys);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		t_reset();
		t_grant();
		t_tier();
		t_rotate();
		t_bridge();
		t_mask();
		t_timeout();
		end_sim();
	end
	initial
	begin
		repeat (3000) @(posedge clk_sys);
		bad_count++;
		end_sim();
	end
endmodule
